// File: hw/icpfce_engine.sv
// programming-port command engine: flash write/read, crc, autobaud, test-mode registers
`timescale 1ns/100ps
`include "icpfce_params.svh"

module icpfce_engine
    import icpfce_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic [11:0] baud_value,
    input wire icpfce_flash_opt_s flash_opt,
    input wire logic [7:0] flash_rdata,
    input wire logic prog_done,
    output icpfce_flash_req_s flash_req,
    output logic flash_access_enable,
    output logic pin_access_mode,
    output logic sector_guard_bypass,
    output logic mass_erase_allow
);

    icpfce_regs_s s_r;
    icpfce_regs_s s_nxt;
    logic push;
    logic [7:0] push_data;
    logic pop;
    logic room;
    logic [7:0] status;

    function automatic logic [16:0] mem_size(input logic big);
        mem_size = big ? `ICPFCE_MEM_64K : `ICPFCE_MEM_32K;
    endfunction

    // zero and oversize both mean the whole main memory
    function automatic logic [16:0] eff_size(input logic [15:0] sz, input logic big);
        logic [16:0] lim;
        lim = mem_size(big);
        if (sz == 16'h0000) begin
            eff_size = lim;
        end else if ({1'b0, sz} > lim) begin
            eff_size = lim;
        end else begin
            eff_size = {1'b0, sz};
        end
    endfunction

    // main-memory protection from the option byte
    function automatic logic main_prot(input logic [15:0] a, input icpfce_flash_opt_s o);
        logic [16:0] half;
        half = mem_size(o.mem_is_64k) >> 1;
        main_prot = !o.info_sel && (o.protect_all || (o.protect_lower && ({1'b0, a} < half)));
    endfunction

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ `ICPFCE_CRC_POLY) : (r << 1);
        end
        crc_byte = r;
    endfunction

    // status is assembled live so the host sees the current port and device state
    always_comb begin
        status = 8'h00;
        status[`ICPFCE_ST_BUSY_BIT] = (s_r.st != ICPFCE_IDLE);
        status[`ICPFCE_ST_PIN_BIT] = s_r.tmode[`ICPFCE_TM_PIN_BIT];
        status[`ICPFCE_ST_UNLOCK_BIT] = flash_opt.unlocked;
        status[`ICPFCE_ST_DROP_BIT] = s_r.drop_seen;
        status[`ICPFCE_ST_FAE_BIT] = s_r.ctl[`ICPFCE_CTL_FAE_BIT];
    end

    assign room = (s_r.buf_fill != 2'h2);
    assign tx_valid = (s_r.buf_fill != 2'h0);
    assign tx_data = s_r.buf_q[s_r.buf_rp];
    assign pop = tx_valid && tx_ready;
    // bytes arrive already framed by the serial receiver
    assign rx_ready = (s_r.st == ICPFCE_IDLE) || (s_r.st == ICPFCE_ARG) ||
                      (s_r.st == ICPFCE_WDATA) || (s_r.st == ICPFCE_REGW);
    assign flash_req = s_r.flash;
    assign flash_access_enable = s_r.ctl[`ICPFCE_CTL_FAE_BIT];
    assign pin_access_mode = s_r.tmode[`ICPFCE_TM_PIN_BIT];
    assign sector_guard_bypass = s_r.ctl[`ICPFCE_CTL_FAE_BIT];
    assign mass_erase_allow = s_r.ctl[`ICPFCE_CTL_FAE_BIT];

    always_comb begin
        s_nxt = s_r;
        s_nxt.flash.rd = 1'b0;
        s_nxt.flash.prog = 1'b0;
        push = 1'b0;
        push_data = 8'h00;
        unique case (s_r.st)
            ICPFCE_IDLE: begin
                if (rx_valid) begin
                    s_nxt.cmd = rx_data;
                    s_nxt.argcnt = 2'h0;
                    case (rx_data)
                        `ICPFCE_OP_WR_FLASH,
                        `ICPFCE_OP_RD_FLASH: begin
                            s_nxt.st = ICPFCE_ARG;
                        end
                        `ICPFCE_OP_CRC: begin
                            if (!s_r.ctl[`ICPFCE_CTL_FAE_BIT]) begin
                                s_nxt.rsp = `ICPFCE_CRC_OFF;
                                s_nxt.rsp_cnt = 2'h2;
                                s_nxt.st = ICPFCE_SEND;
                            end else begin
                                s_nxt.flash.addr = 16'h0000;
                                s_nxt.count = mem_size(flash_opt.mem_is_64k);
                                s_nxt.crc = `ICPFCE_CRC_INIT;
                                s_nxt.wait_cnt = 2'h0;
                                s_nxt.st = ICPFCE_CRC;
                            end
                        end
                        `ICPFCE_OP_RD_BAUD: begin
                            s_nxt.rsp = {4'h0, baud_value};
                            s_nxt.rsp_cnt = 2'h2;
                            s_nxt.st = ICPFCE_SEND;
                        end
                        `ICPFCE_OP_RD_TEST: begin
                            s_nxt.rsp = {s_r.tmode, 8'h00};
                            s_nxt.rsp_cnt = 2'h1;
                            s_nxt.st = ICPFCE_SEND;
                        end
                        `ICPFCE_OP_RD_CTL: begin
                            s_nxt.rsp = {s_r.ctl, 8'h00};
                            s_nxt.rsp_cnt = 2'h1;
                            s_nxt.st = ICPFCE_SEND;
                        end
                        `ICPFCE_OP_RD_STATUS: begin
                            s_nxt.rsp = {status, 8'h00};
                            s_nxt.rsp_cnt = 2'h1;
                            s_nxt.drop_seen = 1'b0;
                            s_nxt.st = ICPFCE_SEND;
                        end
                        `ICPFCE_OP_WR_TEST,
                        `ICPFCE_OP_WR_CTL: begin
                            s_nxt.st = ICPFCE_REGW;
                        end
                        default: begin
                            // unknown opcodes are ignored; the host times out
                            s_nxt.st = ICPFCE_IDLE;
                        end
                    endcase
                end
            end
            ICPFCE_ARG: begin
                if (rx_valid) begin
                    s_nxt.argcnt = s_r.argcnt + 2'h1;
                    // address then size, each high byte first
                    if (s_r.argcnt[1] == 1'b0) begin
                        s_nxt.flash.addr = {s_r.flash.addr[7:0], rx_data};
                    end else begin
                        s_nxt.size = {s_r.size[7:0], rx_data};
                    end
                    if (s_r.argcnt == `ICPFCE_ARG_LAST) begin
                        s_nxt.count = eff_size({s_r.size[7:0], rx_data}, flash_opt.mem_is_64k);
                        s_nxt.wait_cnt = 2'h0;
                        s_nxt.st = (s_r.cmd == `ICPFCE_OP_WR_FLASH) ? ICPFCE_WDATA : ICPFCE_READ;
                    end
                end
            end
            ICPFCE_WDATA: begin
                if (rx_valid) begin
                    if (!flash_opt.unlocked || !s_r.ctl[`ICPFCE_CTL_FAE_BIT] ||
                        main_prot(s_r.flash.addr, flash_opt) ||
                        (flash_opt.info_sel && flash_opt.protect_all)) begin
                        // dropped byte still consumes count and address
                        s_nxt.drop_seen = 1'b1;
                        s_nxt.flash.addr = s_r.flash.addr + 16'h0001;
                        s_nxt.count = s_r.count - 17'h00001;
                        s_nxt.st = (s_r.count == 17'h00001) ? ICPFCE_IDLE : ICPFCE_WDATA;
                    end else begin
                        s_nxt.flash.wdata = rx_data;
                        s_nxt.flash.prog = 1'b1;
                        s_nxt.st = ICPFCE_PROG;
                    end
                end
            end
            ICPFCE_PROG: begin
                // no write buffer: the next byte waits for the flash
                if (prog_done) begin
                    s_nxt.flash.addr = s_r.flash.addr + 16'h0001;
                    s_nxt.count = s_r.count - 17'h00001;
                    s_nxt.st = (s_r.count == 17'h00001) ? ICPFCE_IDLE : ICPFCE_WDATA;
                end
            end
            ICPFCE_READ: begin
                s_nxt.flash.rd = (s_r.wait_cnt == 2'h0);
                if (s_r.wait_cnt != `ICPFCE_RD_CYCLES) begin
                    s_nxt.wait_cnt = s_r.wait_cnt + 2'h1;
                end else if (room) begin
                    push = 1'b1;
                    push_data = (main_prot(s_r.flash.addr, flash_opt) || !s_r.ctl[`ICPFCE_CTL_FAE_BIT]) ?
                                `ICPFCE_ERASED : flash_rdata;
                    s_nxt.wait_cnt = 2'h0;
                    s_nxt.flash.addr = s_r.flash.addr + 16'h0001;
                    s_nxt.count = s_r.count - 17'h00001;
                    s_nxt.st = (s_r.count == 17'h00001) ? ICPFCE_IDLE : ICPFCE_READ;
                end
            end
            ICPFCE_CRC: begin
                // three clocks per byte, so the reply waits about one memory pass
                s_nxt.flash.rd = (s_r.wait_cnt == 2'h0);
                if (s_r.wait_cnt != `ICPFCE_RD_CYCLES) begin
                    s_nxt.wait_cnt = s_r.wait_cnt + 2'h1;
                end else begin
                    s_nxt.wait_cnt = 2'h0;
                    s_nxt.crc = crc_byte(s_r.crc, flash_rdata);
                    s_nxt.flash.addr = s_r.flash.addr + 16'h0001;
                    s_nxt.count = s_r.count - 17'h00001;
                    if (s_r.count == 17'h00001) begin
                        s_nxt.rsp = crc_byte(s_r.crc, flash_rdata);
                        s_nxt.rsp_cnt = 2'h2;
                        s_nxt.st = ICPFCE_SEND;
                    end
                end
            end
            ICPFCE_SEND: begin
                if (room) begin
                    push = 1'b1;
                    push_data = s_r.rsp[15:8];
                    s_nxt.rsp = {s_r.rsp[7:0], 8'h00};
                    s_nxt.rsp_cnt = s_r.rsp_cnt - 2'h1;
                    s_nxt.st = (s_r.rsp_cnt == 2'h1) ? ICPFCE_IDLE : ICPFCE_SEND;
                end
            end
            ICPFCE_REGW: begin
                if (rx_valid) begin
                    // only the port reaches the test-mode register
                    if (s_r.cmd == `ICPFCE_OP_WR_TEST) begin
                        s_nxt.tmode = rx_data;
                    end else begin
                        s_nxt.ctl = rx_data & `ICPFCE_CTL_WMASK;
                    end
                    s_nxt.st = ICPFCE_IDLE;
                end
            end
        endcase
        // two-entry reply buffer; a stalled receiver halts reads rather than losing bytes
        if (push) begin
            s_nxt.buf_q[s_r.buf_wp] = push_data;
            s_nxt.buf_wp = ~s_r.buf_wp;
        end
        if (pop) begin
            s_nxt.buf_rp = ~s_r.buf_rp;
        end
        s_nxt.buf_fill = s_r.buf_fill + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_r <= '0;
            s_r.st <= ICPFCE_IDLE;
            s_r.ctl <= `ICPFCE_CTL_RESET;
            s_r.tmode <= `ICPFCE_TM_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

// File: hw/icpfce_params.svh
// constants of the programming-port command engine
// Function
// - characters are one start bit, eight data bits LSB first, 1.5 stop bits
// - write opcode takes address and size high bytes first, then data to consecutive locations
// - isolated bytes use separate write commands of size one, six bytes each
// - size zero on write or read means the whole main memory
// - a write size above main memory size is clamped to that size
// - write data is dropped while flash is locked or area is protected
// - read opcode takes address and size, returns bytes from successive locations
// - read-protected main-memory bytes are returned as ff
// - crc opcode returns CRC-CCITT over whole main memory, high byte first
// - crc returns ffff when not in programming mode
// - autobaud read returns four zero bits and bits 11..8, then bits 7..0
// - test-mode write loads the following byte into test-mode register
// - test-mode read returns the test-mode register
// - test-mode register reachable only through port commands, not the processor
// - pin-access test mode routes flash accesses through the I/O pins
// - port program and page erase ignore the sector guard register
// - mass erase may be started through the port
// - each byte program completes before the next write byte is taken
// - each flash read takes two clocks before the byte is sent
// - control register holds the flash access enable flag
// - status register reports port and device state
`ifndef ICPFCE_PARAMS_SVH
`define ICPFCE_PARAMS_SVH

`define ICPFCE_OP_RD_STATUS 8'h02
`define ICPFCE_OP_WR_CTL 8'h04
`define ICPFCE_OP_RD_CTL 8'h05
`define ICPFCE_OP_WR_FLASH 8'h0a
`define ICPFCE_OP_RD_FLASH 8'h0b
`define ICPFCE_OP_CRC 8'h0e
`define ICPFCE_OP_RD_BAUD 8'h1b
`define ICPFCE_OP_WR_TEST 8'hf0
`define ICPFCE_OP_RD_TEST 8'hf1

`define ICPFCE_MEM_32K 17'h08000
`define ICPFCE_MEM_64K 17'h10000
`define ICPFCE_ERASED 8'hff
`define ICPFCE_CRC_OFF 16'hffff
`define ICPFCE_CRC_INIT 16'hffff
`define ICPFCE_CRC_POLY 16'h1021
`define ICPFCE_RD_CYCLES 2'h2
`define ICPFCE_ARG_LAST 2'h3

`define ICPFCE_CTL_RESET 8'h00
`define ICPFCE_CTL_WMASK 8'h80
`define ICPFCE_CTL_FAE_BIT 7
`define ICPFCE_TM_RESET 8'h00
`define ICPFCE_TM_PIN_BIT 0
`define ICPFCE_ST_BUSY_BIT 0
`define ICPFCE_ST_PIN_BIT 1
`define ICPFCE_ST_UNLOCK_BIT 2
`define ICPFCE_ST_DROP_BIT 3
`define ICPFCE_ST_FAE_BIT 7

`endif

// File: hw/icpfce_pkg.sv
// types of the programming-port command engine
package icpfce_pkg;

    typedef enum logic [7:0] {
        ICPFCE_IDLE = 8'h01,
        ICPFCE_ARG = 8'h02,
        ICPFCE_WDATA = 8'h04,
        ICPFCE_PROG = 8'h08,
        ICPFCE_READ = 8'h10,
        ICPFCE_CRC = 8'h20,
        ICPFCE_SEND = 8'h40,
        ICPFCE_REGW = 8'h80
    } icpfce_state_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic prog;
    } icpfce_flash_req_s;

    typedef struct packed {
        logic unlocked;
        logic protect_all;
        logic protect_lower;
        logic mem_is_64k;
        logic info_sel;
    } icpfce_flash_opt_s;

    typedef struct packed {
        icpfce_state_e st;
        logic [7:0] cmd;
        logic [1:0] argcnt;
        logic [15:0] size;
        logic [16:0] count;
        logic [1:0] wait_cnt;
        logic [15:0] crc;
        logic [15:0] rsp;
        logic [1:0] rsp_cnt;
        logic [7:0] ctl;
        logic [7:0] tmode;
        logic drop_seen;
        logic [1:0][7:0] buf_q;
        logic buf_wp;
        logic buf_rp;
        logic [1:0] buf_fill;
        icpfce_flash_req_s flash;
    } icpfce_regs_s;

endpackage

// File: test/icpfce_engine_props.sv
// port assertions for the programming-port command engine
`timescale 1ns/100ps
module icpfce_engine_props
    import icpfce_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic [11:0] baud_value,
    input wire icpfce_flash_opt_s flash_opt,
    input wire logic [7:0] flash_rdata,
    input wire logic prog_done,
    input wire icpfce_flash_req_s flash_req,
    input wire logic flash_access_enable,
    input wire logic pin_access_mode,
    input wire logic sector_guard_bypass,
    input wire logic mass_erase_allow
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_prog_blocks_rx: assert property (flash_req.prog |-> !rx_ready)
        else $error("byte taken during program");
    a_prog_data_byte: assert property (flash_req.prog |-> flash_req.wdata == $past(rx_data))
        else $error("program data not the taken byte");
    a_prog_needs_unlock: assert property (flash_req.prog |->
        $past(flash_opt.unlocked && flash_access_enable))
        else $error("program while locked");
    a_read_slot_gap: assert property (flash_req.rd |=> !flash_req.rd [*2])
        else $error("read slot shorter than three cycles");
    // a draining receiver guarantees buffer room, so the slot cannot stall before the step
    a_read_addr_step: assert property (flash_req.rd && tx_ready |->
        ##3 flash_req.addr == $past(flash_req.addr, 3) + 16'h1)
        else $error("read address not stepped");
    a_prog_addr_step: assert property (prog_done && !rx_ready |=>
        flash_req.addr == $past(flash_req.addr) + 16'h1)
        else $error("write address not stepped");
    a_tx_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte lost while stalled");
    a_guard_bypass: assert property (sector_guard_bypass == flash_access_enable)
        else $error("guard bypass off in access mode");
    a_mass_erase_ok: assert property (mass_erase_allow == flash_access_enable)
        else $error("mass erase gate wrong");
    // a reset clears both registers legally, so only changes out of reset are judged
    a_test_reg_port: assert property ($changed(pin_access_mode) && $past(reset_n) |->
        $past(rx_valid && rx_ready))
        else $error("test mode changed without a port byte");
    a_fae_by_cmd: assert property ($changed(flash_access_enable) && $past(reset_n) |->
        $past(rx_valid && rx_ready))
        else $error("access flag changed without a port byte");
endmodule

bind icpfce_engine icpfce_engine_props icpfce_engine_props_inst (.clk(clk), .reset_n(reset_n),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .baud_value(baud_value), .flash_opt(flash_opt), .flash_rdata(flash_rdata),
    .prog_done(prog_done), .flash_req(flash_req), .flash_access_enable(flash_access_enable),
    .pin_access_mode(pin_access_mode), .sector_guard_bypass(sector_guard_bypass),
    .mass_erase_allow(mass_erase_allow));

// File: test/icpfce_flash_model.sv
// flash array model with prompt and slow byte programming
`timescale 1ns/100ps
module icpfce_flash_model
    import icpfce_pkg::*;
(
    input wire logic clk,
    input wire icpfce_flash_req_s flash_req,
    output logic [7:0] flash_rdata,
    output logic prog_done
);
    logic [7:0] mem [logic [15:0]];
    int wait_n = 0;
    initial begin
        flash_rdata = 8'h00;
        prog_done = 1'b0;
    end
    // unwritten cells show a pattern of their address so stale data is visible
    always @(posedge clk) begin
        prog_done <= 1'b0;
        if (flash_req.rd)
            flash_rdata <= mem.exists(flash_req.addr) ? mem[flash_req.addr] : flash_req.addr[7:0] ^ 8'h5a;
        if (flash_req.prog) begin
            mem[flash_req.addr] = flash_req.wdata;
            wait_n = flash_req.addr[0] ? 20 : 2; // odd cells program slowly
        end else if (wait_n > 0) begin
            wait_n--;
            if (wait_n == 0)
                prog_done <= 1'b1;
        end
    end
endmodule

// File: test/icpfce_engine_test.sv
// self-checking bench for the programming-port command engine
`timescale 1ns/100ps
module icpfce_engine_test
    import icpfce_pkg::*;
;
    logic clk, reset_n, rx_valid, rx_ready, tx_valid, tx_ready, prog_done;
    logic flash_access_enable, pin_access_mode, sector_guard_bypass, mass_erase_allow;
    logic [7:0] rx_data, tx_data, flash_rdata;
    logic [11:0] baud_value;
    icpfce_flash_opt_s flash_opt;
    icpfce_flash_req_s flash_req;
    int err_total = 0;
    int total_checks = 0;
    logic [7:0] got [$];
    typedef struct { logic [23:0] cmd; int n; logic [15:0] rsp; int m; } icpfce_row_s;
    icpfce_row_s rows [5] = '{'{24'h0000f1, 1, 16'h0000, 1}, '{24'h00000e, 1, 16'hffff, 2},
        '{24'h00001b, 1, 16'h09c3, 2}, '{24'hf0a4f1, 3, 16'h00a4, 1}, '{24'h04ff05, 3, 16'h0080, 1}};

    icpfce_engine icpfce_engine_inst (.clk(clk), .reset_n(reset_n), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .baud_value(baud_value), .flash_opt(flash_opt), .flash_rdata(flash_rdata), .prog_done(prog_done),
        .flash_req(flash_req), .flash_access_enable(flash_access_enable), .pin_access_mode(pin_access_mode),
        .sector_guard_bypass(sector_guard_bypass), .mass_erase_allow(mass_erase_allow));
    icpfce_flash_model icpfce_flash_model_inst (.clk(clk), .flash_req(flash_req), .flash_rdata(flash_rdata),
        .prog_done(prog_done));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
        if (reset_n && tx_valid === 1'b1 && tx_ready === 1'b1)
            got.push_back(tx_data);

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // bytes go out back to back, top byte first; rx_ready is judged at the settled falling edge
    task automatic send(input logic [63:0] v, input int n);
        int w;
        @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rx_valid <= 1'b1;
            rx_data <= v[8*(n-1-i) +: 8];
            w = 0;
            do begin
                @(negedge clk);
                w++;
            end while (rx_ready !== 1'b1 && w < 5000);
            if (rx_ready !== 1'b1) check("byte accepted", {7'h00, rx_ready}, 8'h01);
            @(posedge clk);
        end
        rx_valid <= 1'b0;
    endtask

    // host polls for each reply instead of assuming a fixed delay
    task automatic wait_rsp(input int m);
        int w;
        w = 0;
        while (got.size() < m && w < 2000) begin
            @(posedge clk);
            w++;
        end
        repeat (4) @(posedge clk);
    endtask

    task automatic expect_rsp(input string what, input logic [63:0] e, input int m);
        wait_rsp(m);
        check({what, " count"}, 8'(got.size()), 8'(m));
        for (int i = 0; i < m && i < got.size(); i++)
            check(what, got[i], e[8*(m-1-i) +: 8]);
        got.delete();
        $display("test %s done", what);
    endtask

    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        reset_n = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b1;
        baud_value = 12'h9c3;
        flash_opt = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        check("reset outputs", {4'h0, rx_ready, tx_valid, flash_access_enable, pin_access_mode}, 8'h08);
        foreach (rows[r]) begin
            send({40'h0, rows[r].cmd}, rows[r].n);
            expect_rsp("row reply", {48'h0, rows[r].rsp}, rows[r].m);
        end
        check("erase and guard", {6'h00, sector_guard_bypass, mass_erase_allow}, 8'h03);
        send(64'h0a01000003112233, 8);
        // receiver stalls so the two-entry reply buffer fills and holds
        tx_ready <= 1'b0;
        send(64'h0b01000003, 5);
        repeat (40) @(posedge clk);
        check("stalled reply", {6'h00, got.size() == 0, tx_valid}, 8'h03);
        tx_ready <= 1'b1;
        expect_rsp("write then read", 64'h112233, 3);
        flash_opt.unlocked <= 1'b0;
        send(64'h0a0200000155, 6);
        send(64'h0b02000001, 5);
        expect_rsp("locked write", 64'h5a, 1);
        flash_opt.unlocked <= 1'b1;
        send(64'h02, 1);
        wait_rsp(1);
        check("status", got.size() > 0 ? got[0] & 8'hfe : 8'hxx, 8'h8c);
        got.delete();
        flash_opt.protect_lower <= 1'b1;
        send(64'h0b3fff0002, 5);
        expect_rsp("protected read", 64'hff5a, 2);
        flash_opt.protect_lower <= 1'b0;
        send(64'hf001, 2);
        repeat (3) @(posedge clk);
        check("pin access", {7'h00, pin_access_mode}, 8'h01);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        check("second reset", {6'h00, flash_access_enable, pin_access_mode}, 8'h00);
        tally_and_finish();
    end
endmodule
